// *** hdl/llsw_pkg.sv ***
// Purpose: shared constants and types for the level limit switching block
// Assumes: 32-bit APB, 16-bit signed length values in the selected unit
// Notes: delay values count whole milliseconds
package llsw_pkg;
  // register byte offsets
  localparam logic [7:0] LLSW_CTRL_OFS = 8'h00;
  localparam logic [7:0] LLSW_REFH_OFS = 8'h04;
  localparam logic [7:0] LLSW_HSP_OFS = 8'h08;
  localparam logic [7:0] LLSW_LSP_OFS = 8'h0C;
  localparam logic [7:0] LLSW_HHYS_OFS = 8'h10;
  localparam logic [7:0] LLSW_LHYS_OFS = 8'h14;
  localparam logic [7:0] LLSW_OND_OFS = 8'h18;
  localparam logic [7:0] LLSW_OFFD_OFS = 8'h1C;
  localparam logic [7:0] LLSW_STAT_OFS = 8'h20;
  localparam logic [7:0] LLSW_LVL_OFS = 8'h24;
  // control register field positions
  localparam int LLSW_CTRL_UNITS_BIT = 0;
  localparam int LLSW_CTRL_FIRST_OUTPUT_BIT = 1;
  localparam int LLSW_CTRL_SECOND_OUTPUT_LSB = 2;
  localparam int LLSW_CTRL_PNP_BIT = 4;
  localparam int LLSW_CTRL_WP_BIT = 5;
  localparam int LLSW_CTRL_HEN_BIT = 6;
  localparam int LLSW_CTRL_LEN_BIT = 7;
  localparam int LLSW_CTRL_ONALL_BIT = 8;
  // status register field positions
  localparam int LLSW_STAT_ALARM_BIT = 0;
  localparam int LLSW_STAT_HIGH_BIT = 1;
  localparam int LLSW_STAT_LOW_BIT = 2;
  localparam int LLSW_STAT_LOST_BIT = 3;
  localparam int LLSW_STAT_FAULT_BIT = 4;
  localparam int LLSW_STAT_WAIT_BIT = 5;
  // reset values
  localparam logic [15:0] LLSW_VAL_RST = 16'h0000;
  localparam logic [15:0] LLSW_OND_RST = 16'h0000;
  localparam logic [15:0] LLSW_OFFD_RST = 16'h0000;
  // timing: one delay step
  localparam int LLSW_CLK_PERIOD_NS = 20;
  localparam int LLSW_DELAY_STEP_NS = 1000000;
  localparam int LLSW_DELAY_STEP_CYC = LLSW_DELAY_STEP_NS / LLSW_CLK_PERIOD_NS;
  localparam int LLSW_VAL_W = 16;

  typedef enum logic [1:0] {
    LLSW_SECOND_OUTPUT_OFF = 2'b00,
    LLSW_SECOND_OUTPUT_ANALOG = 2'b01,
    LLSW_SECOND_OUTPUT_SWITCH = 2'b10
  } llsw_second_output_t;

  typedef enum logic [1:0] {
    LLSW_NORMAL = 2'b00,
    LLSW_ON_WAIT = 2'b01,
    LLSW_ALARM = 2'b10,
    LLSW_OFF_WAIT = 2'b11
  } llsw_state_t;
endpackage

// *** hdl/llsw_level_limit.sv ***
// Purpose: level limit switching logic with APB configuration registers
// Assumes: measurement inputs come from logic on pclk; zero-wait APB slave
// Notes: both switching outputs share one alarm state machine
// Notes: delays count step ticks of STEP_CYC clocks, so up to one step of slack
// Notes: second output level saturates at the 16-bit signed maximum
// Notes on behaviour
// [RL1] level is reference height minus distance
// [RL2] unit setting metric or imperial, values follow
// [RL3] first output disabled or normally open switch
// [RL4] disabled first output leaves line for link
// [RL5] second output off, analog, or switch
// [RL6] second switch shares first output alarm settings
// [RL7] one polarity setting, sourcing or sinking
// [RL8] write protect rejects configuration changes
// [RL9] high alarm enable; disabled means no high
// [RL10] low alarm enable; disabled means no low
// [RL11] level above high set point raises alarm
// [RL12] level below low set point raises alarm
// [RL13] alarm clears only past hysteresis zone
// [RL14] separate hysteresis for high and low
// [RL15] on-delay before entering alarm state
// [RL16] off-delay before returning to normal
// [RL17] on-delay for all or lost-surface only
// [RL18] delay timers restart when condition vanishes
`timescale 1ns/1ps
module llsw_level_limit
  import llsw_pkg::*;
#(
  parameter int STEP_CYC = llsw_pkg::LLSW_DELAY_STEP_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [llsw_pkg::LLSW_VAL_W-1:0] meas_distance,
  input wire logic meas_valid,
  input wire logic hw_fault,
  output logic units_imperial,
  output logic first_output_link_free,
  output logic first_switch_output_src,
  output logic first_switch_output_snk,
  output logic second_output_src,
  output logic second_output_snk,
  output logic second_output_analog_en,
  output logic [llsw_pkg::LLSW_VAL_W-1:0] second_output_level
);
  import llsw_pkg::*;

  // every flop of the block lives in this record, registered in one place
  typedef struct packed {
    logic units;
    logic first_output_switch;
    llsw_second_output_t second_output_mode;
    logic pnp;
    logic wp;
    logic high_en;
    logic low_en;
    logic on_all;
    logic [15:0] ref_height;
    logic [15:0] high_sp;
    logic [15:0] low_sp;
    logic [15:0] high_hys;
    logic [15:0] low_hys;
    logic [15:0] on_delay;
    logic [15:0] off_delay;
    logic high_lim;
    logic low_lim;
    llsw_state_t state;
    logic [31:0] step_cnt;
    logic [15:0] dly_cnt;
    logic [16:0] level;
    logic [31:0] rdata;
    logic sw_on;
    logic an_en;
    logic [15:0] an_level;
  } llsw_regs_t;

  llsw_regs_t r;
  llsw_regs_t next_r;

  // decode, compare and condition helpers, all combinational
  logic [31:0] ctrl_word;
  logic [31:0] stat_word;
  logic [31:0] rd_mux;
  logic addr_ok;
  logic access;
  logic wr_en;
  logic wr_reject;
  logic step;
  logic lost;
  logic [17:0] lvl_x;
  logic [17:0] hsp_x;
  logic [17:0] lsp_x;
  logic [17:0] hclr_x;
  logic [17:0] lclr_x;
  logic hard_cond;
  logic any_cond;
  logic delayed_cond;
  logic second_output_switch;

  // sign-extend a 16-bit value for 18-bit compares, avoids overflow at the rails
  function automatic logic [17:0] ext16(input logic [15:0] v);
    ext16 = {{2{v[15]}}, v};
  endfunction

  // register views and address decode
  always_comb begin
    // control view
    ctrl_word = 32'h0000_0000;
    ctrl_word[LLSW_CTRL_UNITS_BIT] = r.units;
    ctrl_word[LLSW_CTRL_FIRST_OUTPUT_BIT] = r.first_output_switch;
    ctrl_word[LLSW_CTRL_SECOND_OUTPUT_LSB +: 2] = r.second_output_mode;
    ctrl_word[LLSW_CTRL_PNP_BIT] = r.pnp;
    ctrl_word[LLSW_CTRL_WP_BIT] = r.wp;
    ctrl_word[LLSW_CTRL_HEN_BIT] = r.high_en;
    ctrl_word[LLSW_CTRL_LEN_BIT] = r.low_en;
    ctrl_word[LLSW_CTRL_ONALL_BIT] = r.on_all;
    // status view; lost and fault are live inputs, not latched
    stat_word = 32'h0000_0000;
    stat_word[LLSW_STAT_ALARM_BIT] = r.sw_on;
    stat_word[LLSW_STAT_HIGH_BIT] = r.high_lim;
    stat_word[LLSW_STAT_LOW_BIT] = r.low_lim;
    stat_word[LLSW_STAT_LOST_BIT] = ~meas_valid;
    stat_word[LLSW_STAT_FAULT_BIT] = hw_fault;
    stat_word[LLSW_STAT_WAIT_BIT] = (r.state == LLSW_ON_WAIT) || (r.state == LLSW_OFF_WAIT);
    // read mux; unmapped offsets read zero and flag an error
    addr_ok = 1'b1;
    case (paddr)
      LLSW_CTRL_OFS: rd_mux = ctrl_word;
      LLSW_REFH_OFS: rd_mux = {16'h0000, r.ref_height};
      LLSW_HSP_OFS: rd_mux = {16'h0000, r.high_sp};
      LLSW_LSP_OFS: rd_mux = {16'h0000, r.low_sp};
      LLSW_HHYS_OFS: rd_mux = {16'h0000, r.high_hys};
      LLSW_LHYS_OFS: rd_mux = {16'h0000, r.low_hys};
      LLSW_OND_OFS: rd_mux = {16'h0000, r.on_delay};
      LLSW_OFFD_OFS: rd_mux = {16'h0000, r.off_delay};
      LLSW_STAT_OFS: rd_mux = stat_word;
      LLSW_LVL_OFS: rd_mux = {{15{r.level[16]}}, r.level};
      default: begin
        rd_mux = 32'h0000_0000;
        addr_ok = 1'b0;
      end
    endcase
  end

  // apb handshake: zero wait, error on unmapped or protected write
  // pready tied high: every access completes in its first access cycle
  assign access = psel & penable;
  assign wr_reject = pwrite & r.wp & (paddr != LLSW_CTRL_OFS); // RL8
  assign wr_en = access & pwrite & addr_ok & ~wr_reject;
  assign pready = 1'b1;
  assign pslverr = access & (~addr_ok | wr_reject | (pwrite & paddr == LLSW_STAT_OFS)
                   | (pwrite & paddr == LLSW_LVL_OFS));

  // limit comparisons on signed level; clear points sit one hysteresis back
  // 18 bits keep set point minus hysteresis from wrapping at the rails
  assign lvl_x = {r.level[16], r.level};
  assign hsp_x = ext16(r.high_sp);
  assign lsp_x = ext16(r.low_sp);
  assign hclr_x = hsp_x - {2'b00, r.high_hys}; // RL14
  assign lclr_x = lsp_x + {2'b00, r.low_hys}; // RL14
  assign lost = ~meas_valid;
  assign step = (r.step_cnt == 32'(STEP_CYC - 1));
  // set-point crossings and faults skip the delay unless it applies to all
  assign hard_cond = r.high_lim | r.low_lim | hw_fault;
  assign any_cond = hard_cond | lost;
  assign delayed_cond = r.on_all ? any_cond : lost; // RL17

  // second output follows the alarm only in switch mode
  assign second_output_switch = (r.second_output_mode == LLSW_SECOND_OUTPUT_SWITCH); // RL6

  // next-state of all registers
  always_comb begin
    next_r = r;
    // free-running step tick shared by both delay timers
    next_r.step_cnt = step ? 32'h0000_0000 : r.step_cnt + 32'h0000_0001;
    // level held at last good value while the surface is lost
    // 17-bit difference, so a full-scale distance cannot wrap
    if (meas_valid) begin
      next_r.level = 17'($signed(r.ref_height) - $signed(meas_distance)); // RL1
    end
    // read data captured in the setup phase so prdata comes from a flop
    if (psel & ~penable) begin
      next_r.rdata = pwrite ? 32'h0000_0000 : rd_mux;
    end
    // configuration writes; protect lets only the protect bit through
    if (wr_en) begin
      case (paddr)
        LLSW_CTRL_OFS: begin
          next_r.wp = pwdata[LLSW_CTRL_WP_BIT]; // RL8
          if (!r.wp) begin
            next_r.units = pwdata[LLSW_CTRL_UNITS_BIT]; // RL2
            next_r.first_output_switch = pwdata[LLSW_CTRL_FIRST_OUTPUT_BIT]; // RL3
            // reserved encoding falls back to disabled
            next_r.second_output_mode = (pwdata[LLSW_CTRL_SECOND_OUTPUT_LSB +: 2] == 2'b11) ? LLSW_SECOND_OUTPUT_OFF
                               : llsw_second_output_t'(pwdata[LLSW_CTRL_SECOND_OUTPUT_LSB +: 2]); // RL5
            next_r.pnp = pwdata[LLSW_CTRL_PNP_BIT]; // RL7
            next_r.high_en = pwdata[LLSW_CTRL_HEN_BIT]; // RL9
            next_r.low_en = pwdata[LLSW_CTRL_LEN_BIT]; // RL10
            next_r.on_all = pwdata[LLSW_CTRL_ONALL_BIT]; // RL17
          end
        end
        // protected and unmapped writes never get here since wr_en masks them; refused status and level writes hit the default
        LLSW_REFH_OFS: next_r.ref_height = pwdata[15:0];
        LLSW_HSP_OFS: next_r.high_sp = pwdata[15:0];
        LLSW_LSP_OFS: next_r.low_sp = pwdata[15:0];
        LLSW_HHYS_OFS: next_r.high_hys = pwdata[15:0];
        LLSW_LHYS_OFS: next_r.low_hys = pwdata[15:0];
        LLSW_OND_OFS: next_r.on_delay = pwdata[15:0];
        LLSW_OFFD_OFS: next_r.off_delay = pwdata[15:0];
        default: next_r.wp = r.wp;
      endcase
    end

    // high limit: set above set point, hold until below clear point
    if (!r.high_en) begin
      next_r.high_lim = 1'b0; // RL9
    end else if ($signed(lvl_x) > $signed(hsp_x)) begin
      next_r.high_lim = 1'b1; // RL11
    end else if ($signed(lvl_x) < $signed(hclr_x)) begin
      next_r.high_lim = 1'b0; // RL13
    end

    // low limit mirrors the high one
    if (!r.low_en) begin
      next_r.low_lim = 1'b0; // RL10
    end else if ($signed(lvl_x) < $signed(lsp_x)) begin
      next_r.low_lim = 1'b1; // RL12
    end else if ($signed(lvl_x) > $signed(lclr_x)) begin
      next_r.low_lim = 1'b0; // RL13
    end

    // alarm sequencing; a zero delay switches at once
    case (r.state)
      LLSW_NORMAL: begin
        // hard conditions may skip the wait, the rest start the on-delay
        next_r.dly_cnt = 16'h0000;
        if ((hard_cond && !r.on_all) || (any_cond && r.on_delay == 16'h0000)) begin
          next_r.state = LLSW_ALARM; // RL17
        end else if (delayed_cond) begin
          next_r.state = LLSW_ON_WAIT; // RL15
        end
      end
      LLSW_ON_WAIT: begin
        // a vanished condition drops the wait, so the count restarts
        if (hard_cond && !r.on_all) begin
          next_r.state = LLSW_ALARM; // RL17
        end else if (!delayed_cond) begin
          next_r.state = LLSW_NORMAL; // RL18
        end else if (step) begin
          next_r.dly_cnt = r.dly_cnt + 16'h0001;
          if (r.dly_cnt + 16'h0001 >= r.on_delay) begin
            next_r.state = LLSW_ALARM; // RL15
          end
        end
      end
      LLSW_ALARM: begin
        // leave only once every condition is gone
        next_r.dly_cnt = 16'h0000;
        if (!any_cond) begin
          next_r.state = (r.off_delay == 16'h0000) ? LLSW_NORMAL : LLSW_OFF_WAIT; // RL16
        end
      end
      LLSW_OFF_WAIT: begin
        // a returning condition aborts the off-delay
        if (any_cond) begin
          next_r.state = LLSW_ALARM; // RL18
        end else if (step) begin
          next_r.dly_cnt = r.dly_cnt + 16'h0001;
          if (r.dly_cnt + 16'h0001 >= r.off_delay) begin
            next_r.state = LLSW_NORMAL; // RL16
          end
        end
      end
      default: next_r.state = LLSW_NORMAL;
    endcase

    // each wait phase starts counting from zero
    if (next_r.state != r.state) begin
      next_r.dly_cnt = 16'h0000; // RL18
    end
    next_r.sw_on = (next_r.state == LLSW_ALARM) || (next_r.state == LLSW_OFF_WAIT);
    // analog enable follows the mode written this edge, never overlapping a switch
    next_r.an_en = (next_r.second_output_mode == LLSW_SECOND_OUTPUT_ANALOG); // RL5
    // analog path clamps negative level to zero and saturates above the signed maximum;
    // scaling happens downstream
    next_r.an_level = r.level[16] ? 16'h0000
                      : (r.level[15] ? 16'h7FFF : r.level[15:0]);
  end

  // single state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      // every field named so each reset value is visible here
      r.units <= 1'b0;
      r.first_output_switch <= 1'b0;
      r.second_output_mode <= LLSW_SECOND_OUTPUT_OFF;
      r.pnp <= 1'b0;
      r.wp <= 1'b0;
      r.high_en <= 1'b0;
      r.low_en <= 1'b0;
      r.on_all <= 1'b0;
      r.ref_height <= LLSW_VAL_RST;
      r.high_sp <= LLSW_VAL_RST;
      r.low_sp <= LLSW_VAL_RST;
      r.high_hys <= LLSW_VAL_RST;
      r.low_hys <= LLSW_VAL_RST;
      r.on_delay <= LLSW_OND_RST;
      r.off_delay <= LLSW_OFFD_RST;
      r.high_lim <= 1'b0;
      r.low_lim <= 1'b0;
      r.state <= LLSW_NORMAL;
      r.step_cnt <= 32'h0000_0000;
      r.dly_cnt <= 16'h0000;
      r.level <= 17'h0_0000;
      r.rdata <= 32'h0000_0000;
      r.sw_on <= 1'b0;
      r.an_en <= 1'b0;
      r.an_level <= 16'h0000;
    end else begin
      r <= next_r;
    end
  end

  // normally open switches: closed in alarm and off-delay, one polarity for both
  assign first_switch_output_src = r.first_output_switch & r.sw_on & r.pnp; // RL3 RL7
  assign first_switch_output_snk = r.first_output_switch & r.sw_on & ~r.pnp; // RL3 RL7
  assign second_output_src = second_output_switch & r.sw_on & r.pnp; // RL6
  assign second_output_snk = second_output_switch & r.sw_on & ~r.pnp; // RL6
  // disabled first output leaves the line free for the link
  assign first_output_link_free = ~r.first_output_switch; // RL4

  // plain register views
  assign units_imperial = r.units; // RL2
  assign second_output_analog_en = r.an_en;
  assign second_output_level = r.an_level;
  assign prdata = r.rdata;
endmodule

// *** verif/llsw_chk.sv ***
// Purpose: port-level checks of the level limit switch block
// Assumes: zero-wait APB, mirror tracks accepted control writes
// Notes: one clock domain, so default clocking is used
`timescale 1ns/1ps
module llsw_chk
  import llsw_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pslverr,
  input wire logic hw_fault,
  input wire logic first_output_link_free,
  input wire logic first_switch_output_src,
  input wire logic first_switch_output_snk,
  input wire logic second_output_src,
  input wire logic second_output_snk,
  input wire logic second_output_analog_en,
  input wire logic [15:0] second_output_level
);
  import llsw_pkg::*;
  logic [8:0] ctl_q;
  logic wr_ok;
  assign wr_ok = psel && penable && pwrite && !pslverr && paddr == LLSW_CTRL_OFS;
  // control mirror; while protected only the protect bit may move
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl_q <= 9'h000;
    end else if (wr_ok && ctl_q[5]) begin
      ctl_q[5] <= pwdata[5];
    end else if (wr_ok) begin
      ctl_q <= pwdata[8:0];
    end
  end
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  sequence s_wr;
    psel && penable && pwrite;
  endsequence
  // margin of five cycles covers flag and state pipeline
  sequence s_fault_run;
    (hw_fault && ctl_q[1] && ctl_q[4] && !ctl_q[8])[*5];
  endsequence
  a_protect_refuse: assert property (s_wr ##0 (ctl_q[5] && paddr != LLSW_CTRL_OFS)
    |-> pslverr)
    else $error("protected write not refused");
  a_link_free_mode: assert property (first_output_link_free == !ctl_q[1])
    else $error("link free flag wrong");
  a_link_quiet: assert property (first_output_link_free
    |-> !first_switch_output_src && !first_switch_output_snk)
    else $error("disabled output switched");
  a_polarity_one: assert property (!((first_switch_output_src || second_output_src)
    && (first_switch_output_snk || second_output_snk)))
    else $error("mixed polarity");
  a_src_pnp: assert property ((first_switch_output_src || second_output_src)
    |-> ctl_q[4])
    else $error("source without pnp");
  a_snk_npn: assert property ((first_switch_output_snk || second_output_snk)
    |-> !ctl_q[4])
    else $error("sink without npn");
  a_analog_mode: assert property (second_output_analog_en == (ctl_q[3:2] == 2'b01))
    else $error("analog enable wrong");
  a_analog_quiet: assert property (second_output_analog_en
    |-> !second_output_src && !second_output_snk)
    else $error("analog output switched");
  a_fault_fast: assert property (s_fault_run |-> first_switch_output_src)
    else $error("fault alarm delayed");
  a_level_clamp: assert property (!second_output_level[15])
    else $error("negative level on output");
endmodule

// *** verif/llsw_plc_model.sv ***
// Purpose: far-side reader of one switching output
// Assumes: reader samples the line once per clock
// Notes: sourcing reads high, sinking pulls the input low
`timescale 1ns/1ps
module llsw_plc_model (
  input wire logic pclk,
  input wire logic src,
  input wire logic snk,
  output logic seen
);
  // either polarity means the contact is closed
  always_ff @(posedge pclk) begin
    seen <= src | snk;
  end
endmodule

// *** verif/testbench.sv ***
// Purpose: self-checking bench of the level limit switch block
// Assumes: zero-wait APB, short delay step in simulation
// Notes: bus reads go through a note queue
`timescale 1ns/1ps
module testbench;
  import llsw_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [15:0] meas_distance = 16'h0000;
  logic meas_valid = 1'b0;
  logic hw_fault = 1'b0;
  logic [31:0] prdata;
  logic [15:0] second_output_level;
  logic pready, pslverr, units_imperial, first_output_link_free, plc_seen;
  logic first_switch_output_src, first_switch_output_snk, second_output_src;
  logic second_output_snk, second_output_analog_en;
  logic [32:0] note_q [$];
  logic [32:0] exp_n;
  logic [16:0] lvl;
  logic [31:0] r;
  logic [15:0] cfg [6] = '{16'h03E8, 16'h0320, 16'h00C8, 16'h0032, 16'h001E, 16'h0000};
  int seed = 32'hf9a3;
  int n_errors = 0;
  int checked = 0;
  always #10 pclk = ~pclk;
  llsw_level_limit #(.STEP_CYC(4)) dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .meas_distance, .meas_valid, .hw_fault,
    .units_imperial, .first_output_link_free, .first_switch_output_src,
    .first_switch_output_snk, .second_output_src, .second_output_snk,
    .second_output_analog_en, .second_output_level);
  llsw_plc_model plc (.pclk, .src(first_switch_output_src), .snk(first_switch_output_snk),
    .seen(plc_seen));
  task automatic summarize();
    $display("checked %0d n_errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic cmp(input logic [32:0] g, input logic [32:0] e);
    checked++;
    if (g !== e) begin
      n_errors++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  // one APB transfer; the answer is awaited under a bound
  task automatic xf(input logic w, input logic [7:0] a, input logic [31:0] d,
    input logic [32:0] e);
    int k;
    note_q.push_back(e);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (pready !== 1'b1) begin
      n_errors++;
      summarize();
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic ct(input logic [8:0] c);
    xf(1'b1, LLSW_CTRL_OFS, {23'h0, c}, 33'h0);
  endtask
  task automatic lv(input logic [15:0] d, input int n);
    meas_distance <= d;
    repeat (n) @(posedge pclk);
  endtask
  // order: units, link free, analog, first src/snk, second src/snk
  task automatic pin(input logic [6:0] e);
    cmp({26'h0, units_imperial, first_output_link_free, second_output_analog_en,
      first_switch_output_src, first_switch_output_snk, second_output_src,
      second_output_snk}, {26'h0, e});
    cmp({32'h0, plc_seen}, {32'h0, e[3] | e[2]});
  endtask
  // watcher; on writes only the error flag is meaningful
  always @(posedge pclk) begin
    if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1 && note_q.size() > 0) begin
      exp_n = note_q.pop_front();
      if (pwrite) begin
        cmp({pslverr, 32'h0}, {exp_n[32], 32'h0});
      end else begin
        cmp({pslverr, prdata}, exp_n);
      end
    end
  end
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    pin(7'h20);
    xf(1'b0, LLSW_CTRL_OFS, 32'h0, 33'h0);
    xf(1'b0, 8'h28, 32'h0, {1'b1, 32'h0});
    for (int i = 0; i < 6; i++) begin
      xf(1'b1, 8'(4 * i + 4), {16'h0, cfg[i]}, 33'h0);
    end
    ct(9'h0DA);
    meas_valid <= 1'b1;
    lv(16'h0258, 6);
    pin(7'h00);
    xf(1'b0, LLSW_LVL_OFS, 32'h0, 33'h190);
    lv(16'h00C8, 6);
    pin(7'h00);
    lv(16'h0064, 6);
    pin(7'h0A);
    lv(16'h00FA, 6);
    pin(7'h0A);
    lv(16'h0104, 6);
    pin(7'h00);
    lv(16'h0064, 6);
    ct(9'h09A);
    lv(16'h0064, 6);
    pin(7'h00);
    lv(16'h0384, 6);
    pin(7'h0A);
    lv(16'h02FD, 6);
    pin(7'h00);
    lv(16'h0384, 6);
    ct(9'h01A);
    lv(16'h0384, 6);
    pin(7'h00);
    ct(9'h0CA);
    lv(16'h0384, 6);
    pin(7'h05);
    ct(9'h0C6);
    lv(16'h0384, 6);
    pin(7'h14);
    cmp({17'h0, second_output_level}, 33'h64);
    lv(16'h04B0, 6);
    cmp({17'h0, second_output_level}, 33'h0);
    xf(1'b0, LLSW_LVL_OFS, 32'h0, 33'h0FFFFFF38);
    ct(9'h0C5);
    lv(16'h04B0, 6);
    pin(7'h70);
    ct(9'h0E6);
    xf(1'b1, LLSW_HSP_OFS, 32'h0, {1'b1, 32'h0});
    xf(1'b0, LLSW_HSP_OFS, 32'h0, 33'h320);
    ct(9'h000);
    xf(1'b0, LLSW_CTRL_OFS, 32'h0, 33'h0C6);
    lv(16'h0258, 6);
    xf(1'b1, LLSW_OND_OFS, 32'h3, 33'h0);
    xf(1'b1, LLSW_OFFD_OFS, 32'h3, 33'h0);
    ct(9'h1D2);
    lv(16'h0064, 5);
    lv(16'h0258, 20);
    pin(7'h00);
    lv(16'h0064, 5);
    pin(7'h00);
    lv(16'h0064, 20);
    pin(7'h08);
    lv(16'h0258, 5);
    pin(7'h08);
    lv(16'h0258, 20);
    pin(7'h00);
    xf(1'b1, LLSW_OFFD_OFS, 32'h0, 33'h0);
    ct(9'h0D2);
    meas_valid <= 1'b0;
    lv(16'h0258, 5);
    pin(7'h00);
    lv(16'h0258, 20);
    pin(7'h08);
    meas_valid <= 1'b1;
    lv(16'h0258, 6);
    hw_fault <= 1'b1;
    lv(16'h0258, 6);
    pin(7'h08);
    hw_fault <= 1'b0;
    for (int i = 0; i < 8; i++) begin
      r = $random(seed);
      lvl = 17'h003E8 - {7'h0, r[9:0]};
      lv({6'h0, r[9:0]}, 4);
      xf(1'b0, LLSW_LVL_OFS, 32'h0, {1'b0, {15{lvl[16]}}, lvl});
    end
    summarize();
  end
endmodule
bind llsw_level_limit llsw_chk u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
  .pwdata, .pslverr, .hw_fault, .first_output_link_free, .first_switch_output_src,
  .first_switch_output_snk, .second_output_src, .second_output_snk,
  .second_output_analog_en, .second_output_level);
